// ==== rtl/sec_pkg.sv ====
// Package of constants and carrier types for the serial EEPROM client
`default_nettype none
package sec_pkg;
   localparam int        SEC_ADDR_W      = 14;
   localparam int        SEC_PAGE_W      = 6;
   localparam int        SEC_MEM_DEPTH   = 16384;
   localparam logic [13:0] SEC_ADDR_LAST = 14'h3FFF;
   localparam logic [13:0] SEC_ADDR_FIRST = 14'h0000;
   localparam logic [3:0] SEC_DEV_CODE   = 4'h6;   // Device type code, arbitrary value
   localparam logic [2:0] SEC_BIT_LAST   = 3'h7;
   localparam int        SEC_CLK_HZ      = 20000000;
   localparam int        SEC_TWC_US      = 5000;   // Internal write cycle time in microseconds
   localparam int        SEC_TWC_CYC     = (SEC_TWC_US * (SEC_CLK_HZ / 1000000));
   localparam logic [7:0] SEC_RESET_BYTE = 8'hFF;

   typedef enum logic [2:0] {
      SEC_IDLE  = 3'b000,
      SEC_CTRL  = 3'b001,
      SEC_ADRH  = 3'b010,
      SEC_ADRL  = 3'b011,
      SEC_WDATA = 3'b100,
      SEC_RDATA = 3'b101,
      SEC_RACK  = 3'b110,
      SEC_SKIP  = 3'b111
   } sec_state_t;

   // One byte write request from the page buffer into the array
   typedef struct packed {
      logic [13:0] addr;
      logic [7:0]  data;
   } sec_wreq_t;
endpackage
`default_nettype wire

// ==== rtl/sec_mem.sv ====
// Storage array with registered read data and one write port
`default_nettype none
module sec_mem
   import sec_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        clkEn,
   input  wire logic        wrEn,
   input  wire logic [13:0] wrAddr,
   input  wire logic [7:0]  wrData,
   input  wire logic [13:0] rdAddr,
   output logic      [7:0]  rdData
);
   logic [7:0] memArray [0:SEC_MEM_DEPTH-1];

   // Write and registered read; no reset on storage so it maps to RAM
   always_ff @(posedge clk_sys)
   begin
      if (clkEn)
      begin
         if (wrEn)
            memArray[wrAddr] <= wrData;
         rdData <= memArray[rdAddr];
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sec_client.sv ====
// Two-wire serial EEPROM client: protocol, page buffer, write cycle, reads
// Overview of operation
// - Sequential read never leaves this part; pointer wraps inside own array
// - Byte write: control, address high, address low, data, each acked, Stop
// - Stop after write data starts the write cycle; no acks while busy
// - Protected write still acks every byte but writes nothing, stays ready
// - After byte write the pointer holds written address plus one within its page
// - Partial page write leaves the unchanged rest of the page unwritten
// - Up to 63 more bytes buffered, committed only after Stop
// - Only the six low pointer bits count; extra bytes overwrite earlier ones
// - Page write past page end wraps to start of the same page
// - Protect input high blocks writes to the whole array
// - Protect input is sampled at Stop; later changes do not matter
// - After the write cycle a polling control byte is acknowledged
// - Read control without address phase acks and sends pointer data
// - Host ends a read with no ack and Stop; device stops sending
// - Address bytes load the pointer before a repeated Start abandons write
// - After random read the pointer follows the byte sent
// - Each host ack on a read byte sends the next address
// - Sending byte at 3FFF rolls pointer to 0000
// - Only fourteen address bits used; top two of high byte ignored
// - Respond only when select bits equal the select inputs
// - On host no-ack the data line is released high
`default_nettype none
module sec_client
   import sec_pkg::*;
#(
   parameter int TWC_CYCLES = SEC_TWC_CYC
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       chip_select_bit_zero,
   input  wire logic       chip_select_bit_one,
   input  wire logic       chip_select_bit_two,
   input  wire logic       writeProtect,
   output logic            busy
);
   // Pin synchronisers; first stage read only by the second
   logic [1:0] sclSync_reg;
   logic [1:0] sdaSync_reg;
   logic [1:0] wpSync_reg;
   logic [2:0] csSync0_reg;
   logic [2:0] csSync1_reg;
   logic       sclPrev_reg;
   logic       sdaPrev_reg;
   logic       sclRise;
   logic       sclFall;
   logic       startCond;
   logic       stopCond;

   sec_state_t  state_reg;
   logic [2:0]  bitCnt_reg;
   logic        byteFull_reg;
   logic [7:0]  shift_reg;
   logic        ackPhase_reg;
   logic        ctrlRead_reg;
   logic [13:0] addrPtr_reg;
   logic [7:0]  pageBuf_reg [0:63];
   logic [63:0] pageDirty_reg;
   logic        wrPending_reg;
   logic        commit_reg;
   logic [6:0]  commitIdx_reg;
   logic [31:0] busyCnt_reg;
   logic [7:0]  txByte_reg;
   logic        txPend_reg;
   logic        sdaOut_reg;
   logic        memWrEn;
   logic [13:0] memWrAddr;
   logic [7:0]  memWrData;
   logic [13:0] memRdAddr;
   logic [7:0]  memRdData;
   sec_wreq_t   wreq;
   logic        ctrlMatch;

   // Pointer step used for reads only; natural 14-bit wrap
   function automatic logic [13:0] secNextAddr(input logic [13:0] a);
      secNextAddr = (a == SEC_ADDR_LAST) ? SEC_ADDR_FIRST : 14'(a + 14'h0001);
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sclSync_reg <= 2'h3;
         sdaSync_reg <= 2'h3;
         wpSync_reg  <= 2'h0;
         csSync0_reg <= 3'h0;
         csSync1_reg <= 3'h0;
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end
      else if (clkEn)
      begin
         sclSync_reg <= {sclSync_reg[0], sclIn};
         sdaSync_reg <= {sdaSync_reg[0], sdaIn};
         wpSync_reg  <= {wpSync_reg[0], writeProtect};
         csSync0_reg <= {chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero};
         csSync1_reg <= csSync0_reg;
         sclPrev_reg <= sclSync_reg[1];
         sdaPrev_reg <= sdaSync_reg[1];
      end
   end

   // Edge and bus-condition detection on synchronised lines
   assign sclRise   = clkEn && sclSync_reg[1] && !sclPrev_reg;
   assign sclFall   = clkEn && !sclSync_reg[1] && sclPrev_reg;
   assign startCond = clkEn && sclSync_reg[1] && sclPrev_reg && sdaPrev_reg && !sdaSync_reg[1];
   assign stopCond  = clkEn && sclSync_reg[1] && sclPrev_reg && !sdaPrev_reg && sdaSync_reg[1];

   // Code and select match against the control byte just shifted in
   assign ctrlMatch = (shift_reg[7:4] == SEC_DEV_CODE) && (shift_reg[3:1] == csSync1_reg);

   // Protocol engine: bit counting, acks, address and page capture
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg     <= SEC_IDLE;
         bitCnt_reg    <= 3'h0;
         byteFull_reg  <= 1'b0;
         shift_reg     <= 8'h00;
         ackPhase_reg  <= 1'b0;
         ctrlRead_reg  <= 1'b0;
         addrPtr_reg   <= SEC_ADDR_FIRST;
         pageDirty_reg <= 64'h0;
         wrPending_reg <= 1'b0;
         sdaOut_reg    <= 1'b1;
         txPend_reg    <= 1'b0;
      end
      else if (startCond)
      begin
         // Repeated Start abandons a write but keeps the loaded pointer
         state_reg     <= SEC_CTRL;
         bitCnt_reg    <= 3'h0;
         ackPhase_reg  <= 1'b0;
         byteFull_reg  <= 1'b0;
         sdaOut_reg    <= 1'b1;
         // A poll during the commit must not drop bytes still to be written
         if (!commit_reg)
            pageDirty_reg <= 64'h0;
         wrPending_reg <= 1'b0;
      end
      else if (stopCond)
      begin
         state_reg     <= SEC_IDLE;
         sdaOut_reg    <= 1'b1;
         wrPending_reg <= 1'b0;
      end
      else if (sclRise && !ackPhase_reg && state_reg != SEC_IDLE && state_reg != SEC_SKIP
               && state_reg != SEC_RDATA)
      begin
         shift_reg  <= {shift_reg[6:0], sdaSync_reg[1]};
         bitCnt_reg <= 3'(bitCnt_reg + 3'h1);
         // Marks a whole byte; a zero count alone also follows every Start
         byteFull_reg <= (bitCnt_reg == SEC_BIT_LAST);
      end
      else if (sclRise && ackPhase_reg && state_reg == SEC_RACK)
      begin
         // Host ack continues the read, no-ack releases the line
         state_reg <= sdaSync_reg[1] ? SEC_SKIP : SEC_RDATA;
         txPend_reg <= !sdaSync_reg[1];
      end
      else if (sclFall)
      begin
         if (ackPhase_reg)
         begin
            ackPhase_reg <= 1'b0;
            sdaOut_reg   <= 1'b1;
            if (state_reg == SEC_RDATA || txPend_reg)
            begin
               sdaOut_reg <= memRdData[7];
               txByte_reg <= {memRdData[6:0], 1'b1};
               addrPtr_reg <= secNextAddr(addrPtr_reg);
               bitCnt_reg <= 3'h1;
               state_reg  <= SEC_RDATA;
               txPend_reg <= 1'b0;
            end
         end
         else if (state_reg == SEC_RDATA)
         begin
            if (bitCnt_reg == 3'h0)
            begin
               sdaOut_reg   <= 1'b1;
               state_reg    <= SEC_RACK;
               ackPhase_reg <= 1'b1;
            end
            else
            begin
               sdaOut_reg <= txByte_reg[7];
               txByte_reg <= {txByte_reg[6:0], 1'b1};
               bitCnt_reg <= 3'(bitCnt_reg + 3'h1);
            end
         end
         else if (byteFull_reg && state_reg != SEC_IDLE && state_reg != SEC_SKIP
                  && state_reg != SEC_RACK)
         begin
            // Eight bits in: decide on ack for the ninth clock
            ackPhase_reg <= 1'b1;
            byteFull_reg <= 1'b0;
            case (state_reg)
               SEC_CTRL:
               begin
                  if (ctrlMatch && !busy)
                  begin
                     sdaOut_reg   <= 1'b0;
                     ctrlRead_reg <= shift_reg[0];
                     state_reg    <= shift_reg[0] ? SEC_RDATA : SEC_ADRH;
                  end
                  else
                  begin
                     state_reg <= SEC_SKIP;
                  end
               end
               SEC_ADRH:
               begin
                  sdaOut_reg <= 1'b0;
                  addrPtr_reg[13:8] <= shift_reg[5:0];
                  state_reg <= SEC_ADRL;
               end
               SEC_ADRL:
               begin
                  sdaOut_reg <= 1'b0;
                  addrPtr_reg[7:0] <= shift_reg;
                  state_reg <= SEC_WDATA;
               end
               SEC_WDATA:
               begin
                  // Acked even when protected; only low six bits step
                  sdaOut_reg <= 1'b0;
                  pageBuf_reg[addrPtr_reg[5:0]] <= shift_reg;
                  pageDirty_reg[addrPtr_reg[5:0]] <= 1'b1;
                  addrPtr_reg[5:0] <= 6'(addrPtr_reg[5:0] + 6'h01);
                  wrPending_reg <= 1'b1;
               end
               default:
               begin
                  state_reg <= SEC_SKIP;
               end
            endcase
         end
         else if (ackPhase_reg == 1'b0 && state_reg == SEC_RDATA && !ctrlRead_reg)
         begin
            sdaOut_reg <= 1'b1;
         end
      end
      // Dirty marks drop with the last commit slot, so every marked byte lands
      if (!rst && clkEn && commit_reg && commitIdx_reg == 7'h3F)
         pageDirty_reg <= 64'h0;
   end

   // Write cycle: Stop with buffered data and protect low starts commit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         commit_reg    <= 1'b0;
         commitIdx_reg <= 7'h00;
         busyCnt_reg   <= 32'h0;
      end
      else if (clkEn)
      begin
         if (stopCond && wrPending_reg && !wpSync_reg[1] && !busy)
         begin
            commit_reg    <= 1'b1;
            commitIdx_reg <= 7'h00;
            busyCnt_reg   <= 32'(TWC_CYCLES);
         end
         else if (busyCnt_reg != 32'h0)
         begin
            busyCnt_reg <= 32'(busyCnt_reg - 32'h1);
            if (commit_reg)
            begin
               commitIdx_reg <= 7'(commitIdx_reg + 7'h01);
               if (commitIdx_reg == 7'h3F)
                  commit_reg <= 1'b0;
            end
         end
         else
         begin
            commit_reg <= 1'b0;
         end
      end
   end

   // Commit steps the whole page: marked bytes from buffer, others not written
   // Rewriting old data needs a read per byte; here untouched bytes are skipped,
   // which leaves their contents identical to a refresh.
   assign wreq.addr = {addrPtr_reg[13:6], commitIdx_reg[5:0]};
   assign wreq.data = pageBuf_reg[commitIdx_reg[5:0]];
   assign memWrEn   = clkEn && commit_reg && pageDirty_reg[commitIdx_reg[5:0]];
   assign memWrAddr = wreq.addr;
   assign memWrData = wreq.data;
   assign memRdAddr = addrPtr_reg;

   sec_mem uMem
   (
      .clk_sys (clk_sys),
      .clkEn   (clkEn),
      .wrEn    (memWrEn),
      .wrAddr  (memWrAddr),
      .wrData  (memWrData),
      .rdAddr  (memRdAddr),
      .rdData  (memRdData)
   );

   // Open-drain drive: enable only while pulling low
   assign busy   = (busyCnt_reg != 32'h0);
   assign sdaOut = 1'b0;
   assign sdaOe  = !sdaOut_reg;
endmodule
`default_nettype wire

// ==== verif/sec_client_monitor.sv ====
// Checker bound to the serial client ports
`default_nettype none
module sec_client_monitor
   import sec_pkg::*;
#(
   parameter int TWC_CYCLES = SEC_TWC_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic chip_select_bit_zero,
   input wire logic chip_select_bit_one,
   input wire logic chip_select_bit_two,
   input wire logic writeProtect,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int busyCnt_reg;
   // Busy length; cleared while low so a stuck busy shows once past TWC_CYCLES
   always_ff @(posedge clk_sys)
   begin
      if (rst || !busy)
         busyCnt_reg <= 0;
      else if (clkEn)
         busyCnt_reg <= busyCnt_reg + 1;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // Reset check must run during reset itself
   property p_rst_idle; disable iff (1'b0) rst |=> !sdaOe && !busy; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_open_drain; sdaOut == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("data value not low");
   property p_busy_quiet; busy |-> !sdaOe; endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
   property p_busy_wp; $rose(busy) |-> !writeProtect; endproperty
   a_busy_wp: assert property (p_busy_wp) else $error("cycle while protected");
   property p_busy_stop; $rose(busy) |-> sclIn && sdaIn; endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("busy not after stop");
   property p_busy_len; $fell(busy) |-> busyCnt_reg == TWC_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_cap; busyCnt_reg <= TWC_CYCLES; endproperty
   a_busy_cap: assert property (p_busy_cap) else $error("busy too long");
   property p_wp_late; busy && $changed(writeProtect) |=> busy; endproperty
   a_wp_late: assert property (p_wp_late) else $error("protect cut cycle");
   property p_stands; sclIn [*3] |-> $stable(sdaOe); endproperty
   a_stands: assert property (p_stands) else $error("drive moved in high");
   c_busy: cover property ($rose(busy));
   c_ack: cover property ($rose(sdaOe) && !busy);
   c_wp: cover property (busy && $changed(writeProtect));
endmodule
bind sec_client sec_client_monitor #(.TWC_CYCLES(TWC_CYCLES)) sec_client_monitor_i (
   .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .chip_select_bit_zero(chip_select_bit_zero), .chip_select_bit_one(chip_select_bit_one),
   .chip_select_bit_two(chip_select_bit_two), .writeProtect(writeProtect), .busy(busy));
`default_nettype wire

// ==== verif/sec_host.sv ====
// Two-wire bus host model driving clock and data
`default_nettype none
module sec_host
(
   input  wire logic clk_sys,
   input  wire logic sdaWire,
   output var  logic sclOut,
   output var  logic sdaDrv
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus: both released; clock stands still between frames
   initial
   begin
      sclOut = 1'b1;
      sdaDrv = 1'b1;
   end
   // Four cycles make half of the 400 ns link period
   task automatic hold();
      repeat (4) @(posedge clk_sys);
   endtask
   // Data falls with clock high
   task automatic start();
      @(posedge clk_sys);
      sdaDrv <= 1'b1;
      hold();
      sclOut <= 1'b1;
      hold();
      sdaDrv <= 1'b0;
      hold();
      sclOut <= 1'b0;
   endtask
   // Data rises with clock high
   task automatic stop();
      @(posedge clk_sys);
      sdaDrv <= 1'b0;
      hold();
      sclOut <= 1'b1;
      hold();
      sdaDrv <= 1'b1;
      hold();
   endtask
   // Byte MSB first then ack slot; wire read late in high phase
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic [7:0] ao);
      for (int i = 8; i >= 0; i--)
      begin
         @(posedge clk_sys);
         sdaDrv <= (i == 0) ? ai : d[i - 1];
         repeat (3) @(posedge clk_sys);
         sclOut <= 1'b1;
         repeat (3) @(posedge clk_sys);
         if (i > 0)
            q = {q[6:0], sdaWire};
         ao = {7'h00, sdaWire};
         @(posedge clk_sys);
         sclOut <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the serial EEPROM client
`default_nettype none
module testbench
   import sec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TWC = 200;
   logic        clk_sys;
   logic        rst;
   logic        clkEn;
   logic        sclIn;
   logic        sdaDrv;
   logic        sdaOut;
   logic        sdaOe;
   logic        busy;
   logic        writeProtect;
   logic [2:0]  csVal;
   logic [31:0] seed = 32'h0000E6CB;
   logic [31:0] t;
   logic [7:0]  ak;
   logic [13:0] pg;
   logic [7:0]  mem [int];
   int          err_total = 0;
   int          check_count = 0;
   wire logic   sdaWire = sdaDrv & ~sdaOe; // Pull-up wins when nobody pulls
   sec_client #(.TWC_CYCLES(TWC)) sec_client_i (
      .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .chip_select_bit_zero(csVal[0]), .chip_select_bit_one(csVal[1]),
      .chip_select_bit_two(csVal[2]), .writeProtect(writeProtect), .busy(busy));
   sec_host sec_host_i (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclOut(sclIn), .sdaDrv(sdaDrv));
   // 50 ns system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Fixed-seed xorshift
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Control byte: code, straps, direction
   function automatic logic [7:0] ctrl(input logic rd);
      return {SEC_DEV_CODE, csVal, rd};
   endfunction
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   // Bus helpers: send byte, wait for busy level, poll
   task automatic tx(input logic [7:0] d);
      logic [7:0] q;
      sec_host_i.xfer(d, 1'b1, q, ak);
   endtask
   task automatic waitb(input logic lvl, input int lim);
      int k;
      k = 0;
      while (busy !== lvl && k < lim)
      begin
         @(negedge clk_sys);
         k++;
      end
      chk({7'h00, busy}, {7'h00, lvl});
      @(posedge clk_sys);
   endtask
   task automatic poll(input logic [7:0] exp);
      sec_host_i.start();
      tx(ctrl(1'b0));
      sec_host_i.stop();
      chk(ak, exp);
   endtask
   // Write n bytes from a; the model wraps inside the page
   task automatic wr(input logic [13:0] a, input int n);
      sec_host_i.start();
      tx(ctrl(1'b0));
      chk(ak, 8'h00);
      t = xs();
      tx({t[7:6], a[13:8]});
      chk(ak, 8'h00);
      tx(a[7:0]);
      chk(ak, 8'h00);
      for (int i = 0; i < n; i++)
      begin
         t = xs();
         tx(t[7:0]);
         chk(ak, 8'h00);
         if (!writeProtect)
            mem[{a[13:6], a[5:0] + i[5:0]}] = t[7:0];
      end
      sec_host_i.stop();
   endtask
   // Read n bytes from a, last one unacked; setA sends the address first
   task automatic rd(input logic [13:0] a, input logic setA, input int n);
      logic [7:0] q;
      sec_host_i.start();
      if (setA)
      begin
         tx(ctrl(1'b0));
         tx({2'h0, a[13:8]});
         tx(a[7:0]);
         sec_host_i.start();
      end
      tx(ctrl(1'b1));
      chk(ak, 8'h00);
      for (int i = 0; i < n; i++)
      begin
         sec_host_i.xfer(8'hFF, i == n - 1, q, t[7:0]);
         chk(q, mem[a]);
         a = a + 14'h0001;
      end
      sec_host_i.stop();
      chk({7'h00, sdaOe}, 8'h00);
   endtask
   // Verdict
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      rst <= 1'b1;
      clkEn <= 1'b1;
      writeProtect <= 1'b0;
      csVal <= 3'h0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t = xs();
      csVal <= t[2:0];
      repeat (4) @(posedge clk_sys);
      chk({6'h00, busy, sdaOe}, 8'h00);
      for (int s = 0; s < 8; s++)
      begin
         sec_host_i.start();
         tx({(s == 0) ? ~SEC_DEV_CODE : SEC_DEV_CODE, csVal ^ s[2:0], 1'b0});
         sec_host_i.stop();
         chk(ak, 8'h01);
      end
      $display("test select done");
      wr(SEC_ADDR_FIRST, 1);
      waitb(1'b1, 20);
      poll(8'h01);
      waitb(1'b0, TWC);
      poll(8'h00);
      wr(SEC_ADDR_LAST, 1);
      waitb(1'b1, 20);
      writeProtect <= 1'b1;
      waitb(1'b0, TWC);
      writeProtect <= 1'b0;
      wr(14'h3FFE, 1);
      waitb(1'b1, 20);
      waitb(1'b0, TWC);
      rd(SEC_ADDR_LAST, 1'b0, 1);
      rd(SEC_ADDR_LAST, 1'b1, 2);
      $display("test byte write done");
      writeProtect <= 1'b1;
      wr(SEC_ADDR_FIRST, 1);
      repeat (20) @(negedge clk_sys);
      chk({7'h00, busy}, 8'h00);
      poll(8'h00);
      writeProtect <= 1'b0;
      rd(SEC_ADDR_FIRST, 1'b1, 1);
      $display("test protect done");
      t = xs();
      pg = {t[7:0], 6'h3E};
      wr(pg, 67);
      waitb(1'b1, 20);
      waitb(1'b0, TWC);
      rd({pg[13:6], 6'h00}, 1'b1, 63);
      rd({pg[13:6], 6'h3F}, 1'b0, 1);
      $display("test page done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
